//--- verilog/stb_pkg.sv
// constants shared by the second timer block
//
// Behaviour
// - fastest prescaler step is eight clock phase units
// - aux timer, core timer, one capture/reload register
// - each timer: prescaled clock or external count
// - software direction, optionally altered by direction pin
// - toggle latch inverts on core wrap
// - latch clocks aux timer and drives toggle pin
// - core wrap pulse exported for capture/compare timers
// - reload enabled: core wrap loads capture/reload value
// - capture enabled: pin edge copies aux count
// - optional aux clear after each capture
// - capture trigger from peer count/direction inputs
package stb_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PHASE_PER_CLK = 2;
  localparam int RES_PHASE     = 8;
  localparam int BASE_DIV      = RES_PHASE / PHASE_PER_CLK;
  localparam int PRE_W         = 10;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_AUX_CTL  = 8'h00;
  localparam logic [7:0] OFF_CORE_CTL = 8'h04;
  localparam logic [7:0] OFF_AUX_CNT  = 8'h08;
  localparam logic [7:0] OFF_CORE_CNT = 8'h0c;
  localparam logic [7:0] OFF_CAP_RLD  = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  localparam int F_PS_LO      = 0;
  localparam int F_SRC_LO     = 3;
  localparam int F_DOWN       = 5;
  localparam int F_EXTDIR     = 6;
  localparam int F_RUN        = 7;
  localparam int F_CAP_EN     = 8;
  localparam int F_RELOAD     = 8;
  localparam int F_CAP_EDGE   = 9;
  localparam int F_TOG_OE     = 9;
  localparam int F_CAP_SRC    = 11;
  localparam int F_CAP_CLR    = 13;
  localparam int ST_AUX       = 0;
  localparam int ST_CORE      = 1;
  localparam int ST_CAP       = 2;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [2:0]  ST_RST  = 3'h0;
  // ---------------------------------------------------------------
  // aux clock source and capture source
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {SRC_PRESCALE, SRC_PIN, SRC_LATCH, SRC_OFF} stb_src_t;
  typedef enum logic [1:0] {CAP_PIN, CAP_PEER_CNT, CAP_PEER_DIR, CAP_PEER_BOTH} stb_cap_t;
endpackage

//--- verilog/stb_sync.sv
// two-stage synchroniser with a third stage for edge detection
`timescale 1ns/1ps
`default_nettype none
module stb_sync #(
  parameter int W = 7
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_lvl,
  output logic      [W-1:0] o_prev
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign o_lvl  = s2_r;
  assign o_prev = s3_r;
endmodule // stb_sync
`default_nettype wire

//--- verilog/stb_timer.sv
// 16-bit up/down timer with write, clear and reload on wrap
`timescale 1ns/1ps
`default_nettype none
module stb_timer
  import stb_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_tick,
  input  wire logic         i_down,
  input  wire logic         i_wr,
  input  wire logic [W-1:0] i_wr_val,
  input  wire logic         i_clear,
  input  wire logic         i_reload_en,
  input  wire logic [W-1:0] i_reload_val,
  output logic      [W-1:0] o_count,
  output logic              o_wrap
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // wrap: up past all ones, or down past zero
  assign o_wrap = i_tick && (i_down ? (cnt_r == '0) : (&cnt_r));

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_wr)
      cnt_nxt = i_wr_val;
    else if (i_clear)
      cnt_nxt = '0;
    else if (i_tick)
    begin
      if (o_wrap && i_reload_en)
        cnt_nxt = i_reload_val;
      else if (i_down)
        cnt_nxt = cnt_r - 1'b1;
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      cnt_r <= CNT_RST[W-1:0];
    else
      cnt_r <= cnt_nxt;
  end

  assign o_count = cnt_r;
endmodule // stb_timer
`default_nettype wire

//--- verilog/stb_top.sv
// second timer block: aux and core timers, capture/reload register
`timescale 1ns/1ps
`default_nettype none
module stb_top
  import stb_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_core_count_pin,
  input  wire logic        i_aux_count_pin,
  input  wire logic        i_aux_dir_pin,
  input  wire logic        i_core_dir_pin,
  input  wire logic        i_capture_in_pin,
  input  wire logic        i_peer_count_input,
  input  wire logic        i_peer_direction_input,
  output logic             o_toggle_out_pin,
  output logic             o_core_ovf_pulse,
  output logic             o_aux_irq,
  output logic             o_core_irq,
  output logic             o_cap_irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int P_CCNT = 0;
  localparam int P_ACNT = 1;
  localparam int P_ADIR = 2;
  localparam int P_CDIR = 3;
  localparam int P_CAP  = 4;
  localparam int P_PCNT = 5;
  localparam int P_PDIR = 6;

  logic [6:0] pin_lvl;
  logic [6:0] pin_prev;

  stb_sync #(.W(7)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_peer_direction_input, i_peer_count_input, i_capture_in_pin,
                 i_core_dir_pin, i_aux_dir_pin, i_aux_count_pin, i_core_count_pin}),
    .o_lvl     (pin_lvl),
    .o_prev    (pin_prev)
  );

  function automatic logic sel_edge(input logic [1:0] sel, input logic lvl, input logic prev);
    sel_edge = (sel[0] && lvl && !prev) || (sel[1] && !lvl && prev);
  endfunction

  function automatic logic pre_tick(input logic [PRE_W-1:0] cnt, input logic [2:0] ps);
    logic [PRE_W-1:0] mask;
    mask = PRE_W'((BASE_DIV << ps) - 1);
    pre_tick = ((cnt & mask) == mask);
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] aux_ctl_r;
  logic [15:0] aux_ctl_nxt;
  logic [15:0] core_ctl_r;
  logic [15:0] core_ctl_nxt;
  logic [15:0] caprld_r;
  logic [15:0] caprld_nxt;
  logic [2:0]  st_r;
  logic [2:0]  st_nxt;
  logic        latch_r;
  logic        latch_nxt;
  logic        latch_prev_r;
  logic        tog_out_r;
  logic        tog_out_nxt;
  logic        ovf_r;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;

  // bus
  logic        dp_wr_r;
  logic        dp_wr_nxt;
  logic [7:0]  dp_addr_r;
  logic [7:0]  dp_addr_nxt;
  logic [31:0] rdata_nxt;
  logic        addr_ph;
  logic        addr_hit;
  logic        wr_aux_ctl;
  logic        wr_core_ctl;
  logic        wr_aux_cnt;
  logic        wr_core_cnt;
  logic        wr_caprld;
  logic        wr_status;

  // timers
  logic [15:0] aux_cnt;
  logic [15:0] core_cnt;
  logic        aux_wrap;
  logic        core_wrap;
  logic        aux_tick;
  logic        core_tick;
  logic        aux_down;
  logic        core_down;
  logic        cap_evt;
  logic        cap_clr;
  stb_src_t    aux_src;
  stb_cap_t    cap_src;
  logic [1:0]  cap_edge;

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  // hsize ignored: word transfers only
  assign addr_ph     = i_hsel && i_hready && i_htrans[1];
  assign addr_hit    = (i_haddr[31:8] == 24'h00_0000);
  assign wr_aux_ctl  = dp_wr_r && (dp_addr_r == OFF_AUX_CTL);
  assign wr_core_ctl = dp_wr_r && (dp_addr_r == OFF_CORE_CTL);
  assign wr_aux_cnt  = dp_wr_r && (dp_addr_r == OFF_AUX_CNT);
  assign wr_core_cnt = dp_wr_r && (dp_addr_r == OFF_CORE_CNT);
  assign wr_caprld   = dp_wr_r && (dp_addr_r == OFF_CAP_RLD);
  assign wr_status   = dp_wr_r && (dp_addr_r == OFF_STATUS);

  always_comb
  begin
    // writes outside the register window are dropped
    dp_wr_nxt   = addr_ph && i_hwrite && addr_hit;
    dp_addr_nxt = addr_ph ? i_haddr[7:0] : dp_addr_r;
    rdata_nxt   = 32'h0000_0000;
    if (addr_ph && !i_hwrite && addr_hit)
    begin
      case (i_haddr[7:0])
        OFF_AUX_CTL:  rdata_nxt = {16'h0000, aux_ctl_r};
        OFF_CORE_CTL: rdata_nxt = {16'h0000, core_ctl_r};
        OFF_AUX_CNT:  rdata_nxt = {16'h0000, aux_cnt};
        OFF_CORE_CNT: rdata_nxt = {16'h0000, core_cnt};
        OFF_CAP_RLD:  rdata_nxt = {16'h0000, caprld_r};
        OFF_STATUS:   rdata_nxt = {28'h000_0000, latch_r, st_r};
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clock selection and direction
  // ---------------------------------------------------------------
  assign aux_src  = stb_src_t'(aux_ctl_r[F_SRC_LO +: 2]);
  assign cap_src  = stb_cap_t'(aux_ctl_r[F_CAP_SRC +: 2]);
  assign cap_edge = aux_ctl_r[F_CAP_EDGE +: 2];

  always_comb
  begin
    pre_nxt = pre_r + 1'b1;
    aux_tick = 1'b0;
    case (aux_src)
      SRC_PRESCALE: aux_tick = pre_tick(pre_r, aux_ctl_r[F_PS_LO +: 3]);
      SRC_PIN:      aux_tick = pin_lvl[P_ACNT] && !pin_prev[P_ACNT];
      SRC_LATCH:    aux_tick = latch_r && !latch_prev_r;
      default:      aux_tick = 1'b0;
    endcase
    aux_tick = aux_tick && aux_ctl_r[F_RUN];
    if (core_ctl_r[F_SRC_LO])
      core_tick = pin_lvl[P_CCNT] && !pin_prev[P_CCNT];
    else
      core_tick = pre_tick(pre_r, core_ctl_r[F_PS_LO +: 3]);
    core_tick = core_tick && core_ctl_r[F_RUN];
    // direction pin high reverses the software direction
    aux_down  = aux_ctl_r[F_DOWN] ^ (aux_ctl_r[F_EXTDIR] && pin_lvl[P_ADIR]);
    core_down = core_ctl_r[F_DOWN] ^ (core_ctl_r[F_EXTDIR] && pin_lvl[P_CDIR]);
  end

  // ---------------------------------------------------------------
  // the two timers
  // ---------------------------------------------------------------
  stb_timer #(.W(16)) u_aux (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_tick       (aux_tick),
    .i_down       (aux_down),
    .i_wr         (wr_aux_cnt),
    .i_wr_val     (i_hwdata[15:0]),
    .i_clear      (cap_clr),
    .i_reload_en  (1'b0),
    .i_reload_val (16'h0000),
    .o_count      (aux_cnt),
    .o_wrap       (aux_wrap)
  );

  stb_timer #(.W(16)) u_core (
    .i_ref_clk    (i_ref_clk),
    .i_sys_rst    (i_sys_rst),
    .i_tick       (core_tick),
    .i_down       (core_down),
    .i_wr         (wr_core_cnt),
    .i_wr_val     (i_hwdata[15:0]),
    .i_clear      (1'b0),
    .i_reload_en  (core_ctl_r[F_RELOAD]),
    .i_reload_val (caprld_r),
    .o_count      (core_cnt),
    .o_wrap       (core_wrap)
  );

  // ---------------------------------------------------------------
  // capture, latch, flags, control
  // ---------------------------------------------------------------
  always_comb
  begin
    case (cap_src)
      CAP_PIN:       cap_evt = sel_edge(cap_edge, pin_lvl[P_CAP], pin_prev[P_CAP]);
      CAP_PEER_CNT:  cap_evt = sel_edge(cap_edge, pin_lvl[P_PCNT], pin_prev[P_PCNT]);
      CAP_PEER_DIR:  cap_evt = sel_edge(cap_edge, pin_lvl[P_PDIR], pin_prev[P_PDIR]);
      CAP_PEER_BOTH: cap_evt = sel_edge(cap_edge, pin_lvl[P_PCNT], pin_prev[P_PCNT])
                            || sel_edge(cap_edge, pin_lvl[P_PDIR], pin_prev[P_PDIR]);
      default:       cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt && aux_ctl_r[F_CAP_EN];
    cap_clr = cap_evt && aux_ctl_r[F_CAP_CLR];

    aux_ctl_nxt  = wr_aux_ctl ? i_hwdata[15:0] : aux_ctl_r;
    core_ctl_nxt = wr_core_ctl ? i_hwdata[15:0] : core_ctl_r;

    // capture beats a software write in the same cycle
    caprld_nxt = caprld_r;
    if (cap_evt)
      caprld_nxt = aux_cnt;
    else if (wr_caprld)
      caprld_nxt = i_hwdata[15:0];

    latch_nxt   = latch_r ^ core_wrap;
    tog_out_nxt = latch_nxt && core_ctl_nxt[F_TOG_OE];

    // write one to clear; a new event wins over the clear
    st_nxt = st_r;
    if (wr_status)
      st_nxt = st_r & ~i_hwdata[2:0];
    if (aux_wrap)
      st_nxt[ST_AUX] = 1'b1;
    if (core_wrap)
      st_nxt[ST_CORE] = 1'b1;
    if (cap_evt)
      st_nxt[ST_CAP] = 1'b1;
  end

  // ---------------------------------------------------------------
  // register update
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      aux_ctl_r    <= CTL_RST;
      core_ctl_r   <= CTL_RST;
      caprld_r     <= CNT_RST;
      st_r         <= ST_RST;
      latch_r      <= 1'b0;
      latch_prev_r <= 1'b0;
      tog_out_r    <= 1'b0;
      ovf_r        <= 1'b0;
      pre_r        <= '0;
      dp_wr_r      <= 1'b0;
      dp_addr_r    <= 8'h00;
      o_hrdata     <= 32'h0000_0000;
      o_hreadyout  <= 1'b1;
      o_hresp      <= 1'b0;
      o_aux_irq    <= 1'b0;
      o_core_irq   <= 1'b0;
      o_cap_irq    <= 1'b0;
    end
    else
    begin
      aux_ctl_r    <= aux_ctl_nxt;
      core_ctl_r   <= core_ctl_nxt;
      caprld_r     <= caprld_nxt;
      st_r         <= st_nxt;
      latch_r      <= latch_nxt;
      latch_prev_r <= latch_r;
      tog_out_r    <= tog_out_nxt;
      ovf_r        <= core_wrap;
      pre_r        <= pre_nxt;
      dp_wr_r      <= dp_wr_nxt;
      dp_addr_r    <= dp_addr_nxt;
      o_hrdata     <= rdata_nxt;
      o_hreadyout  <= 1'b1;
      o_hresp      <= 1'b0;
      o_aux_irq    <= st_nxt[ST_AUX];
      o_core_irq   <= st_nxt[ST_CORE];
      o_cap_irq    <= st_nxt[ST_CAP];
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  assign o_toggle_out_pin = tog_out_r;
  assign o_core_ovf_pulse = ovf_r;
endmodule // stb_top
`default_nettype wire

//--- sim/stb_assertions.sv
// port checks for the second timer block
`timescale 1ns/1ps
`default_nettype none
module stb_assertions (
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        i_capture_in_pin,
  input wire logic        i_peer_count_input,
  input wire logic        i_peer_direction_input,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_core_ovf_pulse,
  input wire logic        o_aux_irq,
  input wire logic        o_core_irq,
  input wire logic        o_cap_irq
);
  logic       rd_r;
  logic       wr_r;
  logic [2:0] cap_r;
  logic [3:0] age_r;
  wire logic  [2:0] cap_now = {i_capture_in_pin, i_peer_count_input, i_peer_direction_input};
  // data phase flags; cycles since a capture source moved
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      cap_r <= 3'h0;
      age_r <= 4'hf;
    end
    else
    begin
      rd_r  <= i_hsel & i_hready & i_htrans[1] & ~i_hwrite;
      wr_r  <= i_hsel & i_hready & i_htrans[1] & i_hwrite;
      cap_r <= cap_now;
      age_r <= (cap_r != cap_now) ? 4'h0 : (age_r == 4'hf) ? age_r : age_r + 4'h1;
    end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_pulse_gone;
    !o_core_ovf_pulse;
  endsequence
  property p_ready; o_hreadyout; endproperty
  property p_okay; !o_hresp; endproperty
  property p_ovf_single; $rose(o_core_ovf_pulse) |=> s_pulse_gone; endproperty
  property p_ovf_flag; o_core_ovf_pulse |-> o_core_irq; endproperty
  property p_rd_idle; !rd_r |-> o_hrdata == 32'h0; endproperty
  property p_rd_upper; o_hrdata[31:16] == 16'h0; endproperty
  property p_sticky; ($fell(o_aux_irq) || $fell(o_core_irq) || $fell(o_cap_irq)) |-> $past(wr_r); endproperty
  property p_cap_cause; $rose(o_cap_irq) |-> age_r < 4'h8; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  a_okay: assert property (p_okay) else $error("hresp not okay");
  a_ovf_single: assert property (p_ovf_single) else $error("wrap pulse too long");
  a_ovf_flag: assert property (p_ovf_flag) else $error("wrap pulse without flag");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  a_sticky: assert property (p_sticky) else $error("flag dropped without write");
  a_cap_cause: assert property (p_cap_cause) else $error("capture without source edge");
endmodule // stb_assertions
bind stb_top stb_assertions stb_assertions_inst (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .i_capture_in_pin(i_capture_in_pin),
  .i_peer_count_input(i_peer_count_input), .i_peer_direction_input(i_peer_direction_input),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_core_ovf_pulse(o_core_ovf_pulse), .o_aux_irq(o_aux_irq), .o_core_irq(o_core_irq),
  .o_cap_irq(o_cap_irq));
`default_nettype wire

//--- sim/stb_src_model.sv
// external count, direction and capture sources
`timescale 1ns/1ps
`default_nettype none
module stb_src_model (
  input  wire logic i_ref_clk,
  output logic      o_core_count_pin,
  output logic      o_aux_count_pin,
  output logic      o_aux_dir_pin,
  output logic      o_core_dir_pin,
  output logic      o_capture_in_pin,
  output logic      o_peer_count_input,
  output logic      o_peer_direction_input
);
  logic [6:0] lvl_r = 7'h0;
  assign {o_peer_direction_input, o_peer_count_input, o_capture_in_pin, o_core_dir_pin,
          o_aux_dir_pin, o_aux_count_pin, o_core_count_pin} = lvl_r;
  // three cycles each way keeps edges well apart
  task automatic pulse(input int idx);
    lvl_r[idx] <= ~lvl_r[idx];
    repeat (3) @(posedge i_ref_clk);
    lvl_r[idx] <= ~lvl_r[idx];
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic level(input int idx, input logic v);
    lvl_r[idx] <= v;
  endtask
endmodule // stb_src_model
`default_nettype wire

//--- sim/dual_timer_capture_reload_test.sv
// self-checking bench for the second timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload_test;
  import stb_pkg::*;
  logic        i_ref_clk, i_sys_rst, i_hsel, i_hwrite, tog;
  logic [31:0] i_haddr, i_hwdata, q;
  logic [1:0]  i_htrans;
  logic [2:0]  irq;
  logic [2:0]  i_hsize;
  int          num_errors, n_checks, n;
  wire logic [31:0] o_hrdata;
  wire logic   o_hreadyout, o_hresp, o_toggle_out_pin, o_core_ovf_pulse, o_aux_irq, o_core_irq, o_cap_irq;
  wire logic   core_pin, aux_pin, aux_dir, core_dir, cap_pin, peer_cnt, peer_dir;
  stb_top stb_top_inst (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_core_count_pin(core_pin), .i_aux_count_pin(aux_pin), .i_aux_dir_pin(aux_dir),
    .i_core_dir_pin(core_dir), .i_capture_in_pin(cap_pin), .i_peer_count_input(peer_cnt),
    .i_peer_direction_input(peer_dir), .o_toggle_out_pin(o_toggle_out_pin),
    .o_core_ovf_pulse(o_core_ovf_pulse), .o_aux_irq(o_aux_irq), .o_core_irq(o_core_irq),
    .o_cap_irq(o_cap_irq));
  stb_src_model stb_src_model_inst (
    .i_ref_clk(i_ref_clk), .o_core_count_pin(core_pin), .o_aux_count_pin(aux_pin),
    .o_aux_dir_pin(aux_dir), .o_core_dir_pin(core_dir), .o_capture_in_pin(cap_pin),
    .o_peer_count_input(peer_cnt), .o_peer_direction_input(peer_dir));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask
  task automatic final_report;
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for a signal at falling edges, then realign to rising
  task automatic hwait(input bit pulse, input int lim);
    n = 0;
    do
    begin
      @(negedge i_ref_clk);
      n++;
    end
    while ((pulse ? o_core_ovf_pulse : o_hreadyout) !== 1'b1 && n < lim);
    q = o_hrdata;
    tog = o_toggle_out_pin;
    irq = {o_cap_irq, o_core_irq, o_aux_irq};
    if ((pulse ? o_core_ovf_pulse : o_hreadyout) !== 1'b1)
    begin
      num_errors++;
      final_report();
    end
    @(posedge i_ref_clk);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel   <= 1'b1;
    i_haddr  <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    hwait(1'b0, 20);
    i_hsel   <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    hwait(1'b0, 20);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    ahb(1'b0, a, 32'h0);
    check(nm, q, e);
  endtask
  task automatic t_regs;
    for (int a = 0; a < 28; a += 4)
      rd(a[7:0], 32'h0, "reset value");
    ahb(1'b1, 8'h18, 32'hffff);
    rd(8'h18, 32'h0, "unmapped");
    ahb(1'b1, 8'h08, 32'h5a5a1234);
    rd(8'h08, 32'h1234, "aux count");
    ahb(1'b1, 8'h08, 32'h0);
  endtask
  task automatic t_wrap;
    logic tog0;
    ahb(1'b1, 8'h10, 32'hfff0);
    ahb(1'b1, 8'h0c, 32'hfff0);
    ahb(1'b1, 8'h00, 32'h0090);
    ahb(1'b1, 8'h04, 32'h0380);
    hwait(1'b1, 300);
    tog0 = tog;
    hwait(1'b1, 300);
    check("wrap period", n, 64);
    check("toggle pin", tog, !tog0);
    ahb(1'b1, 8'h04, 32'h0);
    rd(8'h08, 32'h1, "latch clocked aux");
    rd(8'h14, 32'h2, "status");
    check("core irq", irq, 32'h2);
    ahb(1'b1, 8'h14, 32'h2);
    rd(8'h14, 32'h0, "flag cleared");
    check("irq cleared", irq, 32'h0);
  endtask
  task automatic t_dir;
    for (int i = 0; i < 2; i++)
    begin
      stb_src_model_inst.level(3, i[0]);
      ahb(1'b1, 8'h0c, 32'h2);
      ahb(1'b1, 8'h04, i ? 32'h00c0 : 32'h00e0);
      hwait(1'b1, 40);
      check("toggle disabled", tog, 32'h0);
      ahb(1'b1, 8'h04, 32'h0);
    end
    stb_src_model_inst.level(3, 1'b0);
    ahb(1'b1, 8'h14, 32'h7);
  endtask
  task automatic t_ext;
    ahb(1'b1, 8'h0c, 32'h0);
    ahb(1'b1, 8'h08, 32'hfffd);
    ahb(1'b1, 8'h00, 32'h0088);
    ahb(1'b1, 8'h04, 32'h0088);
    repeat (5) stb_src_model_inst.pulse(1);
    repeat (3) stb_src_model_inst.pulse(0);
    rd(8'h08, 32'h2, "aux pin count");
    rd(8'h0c, 32'h3, "core pin count");
    rd(8'h14, 32'h1, "aux wrap flag");
    check("aux irq", irq, 32'h1);
    ahb(1'b1, 8'h14, 32'h1);
    ahb(1'b1, 8'h04, 32'h0);
  endtask
  task automatic t_cap;
    logic [31:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = 32'h0101 << i;
      ahb(1'b1, 8'h08, v);
      ahb(1'b1, 8'h00, 32'h2118 | ((i == 1) ? 32'h400 : 32'h200) | (i << 11));
      stb_src_model_inst.pulse((i == 0) ? 4 : (i == 2) ? 6 : 5);
      rd(8'h10, v, "captured aux");
      rd(8'h08, 32'h0, "aux cleared");
      rd(8'h14, 32'h4, "capture flag");
      check("capture irq", irq, 32'h4);
      ahb(1'b1, 8'h14, 32'h4);
    end
    ahb(1'b1, 8'h08, 32'h55);
    ahb(1'b1, 8'h00, 32'h0318);
    stb_src_model_inst.pulse(5);
    rd(8'h10, 32'h0808, "no capture");
  endtask
  initial
  begin
    num_errors = 0;
    n_checks   = 0;
    i_sys_rst  = 1'b1;
    i_hsel     = 1'b0;
    i_hwrite   = 1'b0;
    i_haddr    = 32'h0;
    i_hwdata   = 32'h0;
    i_htrans   = 2'h0;
    i_hsize    = 3'h2;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_wrap();
    t_dir();
    t_ext();
    t_cap();
    final_report();
  end
endmodule // dual_timer_capture_reload_test
`default_nettype wire
